// *** core/cch_bcd.sv ***
/*
 * cch_bcd: serial binary to BCD converter, shift and add three.
 * Assumes a one-cycle start pulse from logic on the same clock; the
 * input word is taken at that edge and the digits stand until the
 * next start.
 */
`default_nettype none
module cch_bcd
   import cch_pkg::*;
(
   input wire logic i_clk, // Clock
   input wire logic i_nrst, // Async reset, active low
   input wire logic i_ce, // Clock enable
   input wire logic i_start, // One-cycle start pulse
   input wire logic [BIN_W-1:0] i_bin, // Unsigned value
   output logic o_done, // One-cycle pulse, digits valid
   output logic [BCD_W-1:0] o_bcd // Ten digits, top digit high
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [5:0] cnt;
      logic [BIN_W-1:0] sh;
      logic [BCD_W-1:0] bcd;
   } cch_bcd_t;

   cch_bcd_t q;
   cch_bcd_t next_q;
   logic [BCD_W-1:0] adj;

   // Every digit of five or more gets three before the shift
   for (genvar g = 0; g < BCD_DIG; g++) begin : g_dig
      assign adj[g*4 +: 4] = (q.bcd[g*4 +: 4] >= 4'h5) ?
         q.bcd[g*4 +: 4] + 4'h3 : q.bcd[g*4 +: 4];
   end

   // One bit per cycle; slow, but far smaller than a divider chain
   always_comb begin
      next_q = q;
      next_q.done = 1'b0;
      if (i_start) begin
         next_q.busy = 1'b1;
         next_q.cnt = BCD_STEPS;
         next_q.sh = i_bin;
         next_q.bcd = '0;
      end else if (q.busy) begin
         next_q.bcd = {adj[BCD_W-2:0], q.sh[BIN_W-1]};
         next_q.sh = {q.sh[BIN_W-2:0], 1'b0};
         next_q.cnt = q.cnt - 6'h01;
         if (q.cnt == 6'h01) begin
            next_q.busy = 1'b0;
            next_q.done = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
      end else if (i_ce) begin
         q <= next_q;
      end
   end

   assign o_done = q.done;
   assign o_bcd = q.bcd;
endmodule
`default_nettype wire

// *** core/cch_calib_cmd.sv ***
/*
 * cch_calib_cmd: calibration command interpreter of a light meter.
 * Takes ASCII command characters, arms or disarms calibration, stores
 * calibration values and sends fixed-column ASCII replies.
 * Assumes characters arrive from a receiver on the same clock, the
 * lock pin is asynchronous and measurements are on the same clock.
 */
// Added by the designer: the APB slave port and the register offsets.
`default_nettype none
// Behaviour
// - zcalAx arms light calibration and replies z A a, lock, CR LF.
// - Arm replies hold z, mode, a or d, lock in columns 0-3, CR LF.
// - Locked waits for unlock to calibrate; unlocked runs at once.
// - zcalBx arms dark calibration and replies z B a, lock, CR LF.
// - zcalDx disarms all modes and replies z x d, lock, CR LF.
// - zcal5 with a number and x stores the light offset.
// - Offset reply is z,5, then value with m in 4-15, CR LF at 16.
// - Each set value is stored and the reply echoes the stored one.
// - zcal6 stores light temperature; value in 4-9, CR LF at 10.
// - Temperatures are kept raw in tenths and echoed from that.
// - The dark period never exceeds 300 seconds.
// - zcal7 stores the dark period; reply value with s in 4-15.
// - zcal8 stores dark temperature; value in 4-9, then CR LF.
// - All stored calibration data can be read back.
module cch_calib_cmd
   import cch_pkg::*;
(
   input wire logic I_CLK, // 100 MHz clock
   input wire logic I_NRST, // Async reset, active low
   input wire logic I_CE, // Clock enable, freezes all state
   input wire logic I_PSEL, // APB select
   input wire logic I_PENABLE, // APB access phase
   input wire logic I_PWRITE, // APB write
   input wire logic [7:0] I_PADDR, // APB byte address
   input wire logic [31:0] I_PWDATA, // APB write data
   output logic [31:0] O_PRDATA, // APB read data
   output logic O_PREADY, // APB ready
   output logic O_PSLVERR, // APB error, unmapped address
   input wire logic I_RX_VALID, // Received character strobe
   input wire logic [7:0] I_RX_DATA, // Received character
   output logic O_TX_VALID, // Reply character valid
   input wire logic I_TX_READY, // Transmitter takes character
   output logic [7:0] O_TX_DATA, // Reply character
   input wire logic I_UNLOCK, // Lock pin, high is unlocked
   input wire logic [31:0] I_MEAS_LIGHT, // Offset, hundredths
   input wire logic [31:0] I_MEAS_DARK, // Dark period, ms
   input wire logic [31:0] I_MEAS_TEMP, // Signed tenths degC
   output logic O_ARM_LIGHT, // Light calibration armed
   output logic O_ARM_DARK, // Dark calibration armed
   output logic O_FW_UPG_EN // Firmware upgrade allowed
);
   typedef struct packed {
      cch_state_t st;
      logic [1:0] idx;
      logic [7:0] op;
      logic [31:0] val;
      logic [1:0] fc;
      logic pt;
      logic neg;
      logic [4:0] col;
      logic txv;
      logic [7:0] txd;
      logic start;
      logic [31:0] bin;
      logic s1;
      logic s2;
      logic arm_l;
      logic arm_d;
      logic en;
      logic [31:0] lofs;
      logic [31:0] ltmp;
      logic [31:0] dper;
      logic [31:0] dtmp;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } cch_regs_t;

   localparam cch_regs_t RST = '{st: ST_IDLE, en: CTRL_EN_RST,
                                 default: '0};

   cch_regs_t q;
   cch_regs_t next_q;
   logic [BCD_W-1:0] bcd;
   logic conv_done;
   logic rx_ok;
   logic resync;
   logic tx_go;
   logic is_arm;
   logic is_tmp;
   logic [4:0] rlen;
   logic [1:0] fmax;
   logic [7:0] hdr_ch;
   logic [31:0] sv;
   logic [31:0] rd;
   logic hit;

   // Reply length per command
   function automatic logic [4:0] rep_len(input logic [7:0] op);
      if (op == CH_UA || op == CH_UB || op == CH_UD) begin
         return LEN_ARM;
      end else if (op == CH_6 || op == CH_8) begin
         return LEN_TMP;
      end
      return LEN_VAL;
   endfunction

   // Fraction digits that the stored form keeps
   function automatic logic [1:0] frac_max(input logic [7:0] op);
      if (op == CH_5) begin
         return FRAC_OFS;
      end else if (op == CH_7) begin
         return FRAC_PER;
      end
      return FRAC_TMP;
   endfunction

   // Dark period clamp
   function automatic logic [31:0] clamp(input logic [31:0] v);
      return (v > DARK_MAX_MS) ? DARK_MAX_MS : v;
   endfunction

   // Reply character at a column, built from the stored digits
   function automatic logic [7:0] char_at(input logic [4:0] col,
      input logic [7:0] op, input logic unl, input logic neg,
      input logic [BCD_W-1:0] dg);
      logic [3:0] f;
      logic [3:0] k;
      logic [3:0] pt;
      logic [4:0] len;
      logic [7:0] c;
      f = 4'(col - COL_FIELD);
      pt = (op == CH_5) ? PT_OFS : PT_PER;
      k = (f > pt) ? f - 4'h1 : f;
      len = rep_len(op);
      c = CH_0;
      if (len == LEN_ARM) begin
         case (col)
            5'h00: c = CH_Z;
            5'h01: c = (op == CH_UD) ? CH_X : op;
            5'h02: c = (op == CH_UD) ? CH_D_LO : CH_A_LO;
            5'h03: c = unl ? CH_UU : CH_UL;
            5'h04: c = CH_CR;
            default: c = CH_LF;
         endcase
      end else if (col == 5'h00) begin
         c = CH_Z;
      end else if (col == 5'h01 || col == 5'h03) begin
         c = CH_COMMA;
      end else if (col == 5'h02) begin
         c = op;
      end else if (col == len - 5'h02) begin
         c = CH_CR;
      end else if (col == len - 5'h01) begin
         c = CH_LF;
      end else if (len == LEN_TMP) begin
         case (f)
            4'h0: c = neg ? CH_MINUS : CH_0 + {4'h0, dg[15:12]};
            4'h1: c = CH_0 + {4'h0, dg[11:8]};
            4'h2: c = CH_0 + {4'h0, dg[7:4]};
            4'h3: c = CH_DOT;
            4'h4: c = CH_0 + {4'h0, dg[3:0]};
            default: c = CH_UC;
         endcase
      end else if (f == FLD_LAST) begin
         c = (op == CH_5) ? CH_M : CH_S;
      end else if (f == pt) begin
         c = CH_DOT;
      end else begin
         c = CH_0 + {4'h0, 4'(dg >> {4'(4'h9 - k), 2'b00})};
      end
      return c;
   endfunction

   // Value to decimal digits for the echo
   cch_bcd u_bcd (
      .i_clk(I_CLK),
      .i_nrst(I_NRST),
      .i_ce(I_CE),
      .i_start(q.start),
      .i_bin(q.bin),
      .o_done(conv_done),
      .o_bcd(bcd)
   );

   // Command decode helpers
   assign rx_ok = I_RX_VALID && q.en;
   assign resync = rx_ok && I_RX_DATA == CH_Z;
   assign tx_go = q.txv && I_TX_READY;
   assign rlen = rep_len(q.op);
   assign fmax = frac_max(q.op);
   assign is_arm = rlen == LEN_ARM;
   assign is_tmp = rlen == LEN_TMP;
   assign hdr_ch = (q.idx == 2'h0) ? CH_C_LO :
                   (q.idx == 2'h1) ? CH_A_LO : CH_L_LO;

   // Register read mux; all calibration data is visible here
   always_comb begin
      rd = '0;
      hit = 1'b1;
      case (I_PADDR)
         A_CTRL: rd[CTRL_EN_BIT] = q.en;
         A_STAT: begin
            rd[SB_ARML] = q.arm_l;
            rd[SB_ARMD] = q.arm_d;
            rd[SB_UNL] = q.s2;
            rd[SB_BUSY] = q.st == ST_CONV || q.st == ST_SEND;
         end
         A_LOFS: rd = q.lofs;
         A_LTMP: rd = q.ltmp;
         A_DPER: rd = q.dper;
         A_DTMP: rd = q.dtmp;
         default: hit = 1'b0;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      next_q = q;
      sv = '0;
      next_q.start = 1'b0;
      // Lock pin synchroniser
      next_q.s1 = I_UNLOCK;
      next_q.s2 = q.s1;
      // Armed calibration runs only while unlocked
      if (q.s2 && q.arm_l) begin
         next_q.lofs = I_MEAS_LIGHT;
         next_q.ltmp = I_MEAS_TEMP;
         next_q.arm_l = 1'b0;
      end
      if (q.s2 && q.arm_d) begin
         next_q.dper = clamp(I_MEAS_DARK);
         next_q.dtmp = I_MEAS_TEMP;
         next_q.arm_d = 1'b0;
      end
      // APB slave: answer in the first access cycle
      next_q.pready = I_PSEL && !I_PENABLE;
      next_q.pslverr = I_PSEL && !I_PENABLE && !hit;
      next_q.prdata = (I_PSEL && !I_PENABLE && !I_PWRITE) ? rd : '0;
      if (I_PSEL && I_PENABLE && I_PWRITE && q.pready &&
          I_PADDR == A_CTRL) begin
         next_q.en = I_PWDATA[CTRL_EN_BIT];
      end
      // Parser and reply sequencer
      case (q.st)
         ST_IDLE: begin
            if (resync) begin
               next_q.st = ST_HDR;
               next_q.idx = 2'h0;
            end
         end
         ST_HDR: begin
            if (rx_ok) begin
               if (I_RX_DATA == hdr_ch) begin
                  next_q.idx = q.idx + 2'h1;
                  next_q.st = (q.idx == 2'h2) ? ST_OP : ST_HDR;
               end else begin
                  next_q.st = resync ? ST_HDR : ST_IDLE;
                  next_q.idx = 2'h0;
               end
            end
         end
         ST_OP: begin
            if (rx_ok) begin
               next_q.op = I_RX_DATA;
               next_q.val = '0;
               next_q.fc = 2'h0;
               next_q.pt = 1'b0;
               next_q.neg = 1'b0;
               next_q.idx = 2'h0;
               if (I_RX_DATA == CH_UA || I_RX_DATA == CH_UB ||
                   I_RX_DATA == CH_UD) begin
                  next_q.st = ST_END;
               end else if (I_RX_DATA >= CH_5 && I_RX_DATA <= CH_8) begin
                  next_q.st = ST_NUM;
               end else begin
                  next_q.st = resync ? ST_HDR : ST_IDLE;
               end
            end
         end
         ST_END: begin
            if (rx_ok) begin
               if (I_RX_DATA == CH_X) begin
                  next_q.arm_l = (q.op == CH_UA) || q.arm_l;
                  next_q.arm_d = (q.op == CH_UB) || q.arm_d;
                  if (q.op == CH_UD) begin
                     next_q.arm_l = 1'b0;
                     next_q.arm_d = 1'b0;
                  end
                  next_q.st = ST_SEND;
                  next_q.col = 5'h00;
                  next_q.txv = 1'b1;
                  next_q.txd = char_at(5'h00, q.op, q.s2, q.neg, bcd);
               end else begin
                  next_q.st = resync ? ST_HDR : ST_IDLE;
               end
            end
         end
         ST_NUM: begin
            if (rx_ok) begin
               if (I_RX_DATA >= CH_0 && I_RX_DATA <= CH_9) begin
                  // Digits past the stored resolution are dropped
                  if (!q.pt || q.fc < fmax) begin
                     next_q.val = 32'(q.val * TEN) +
                                  {28'h0000000, I_RX_DATA[3:0]};
                     next_q.fc = q.pt ? q.fc + 2'h1 : q.fc;
                  end
               end else if (I_RX_DATA == CH_DOT) begin
                  next_q.pt = 1'b1;
               end else if (I_RX_DATA == CH_MINUS) begin
                  next_q.neg = is_tmp;
               end else if (I_RX_DATA == CH_X) begin
                  next_q.st = ST_FIX;
               end else begin
                  next_q.st = resync ? ST_HDR : ST_IDLE;
               end
            end
         end
         ST_FIX: begin
            if (q.fc < fmax) begin
               // Pad missing fraction digits
               next_q.val = 32'(q.val * TEN);
               next_q.fc = q.fc + 2'h1;
            end else begin
               case (q.op)
                  CH_5: begin
                     sv = q.val;
                     next_q.lofs = sv;
                  end
                  CH_7: begin
                     sv = clamp(q.val);
                     next_q.dper = sv;
                  end
                  CH_6: begin
                     sv = q.neg ? 32'(-q.val) : q.val;
                     next_q.ltmp = sv;
                  end
                  default: begin
                     sv = q.neg ? 32'(-q.val) : q.val;
                     next_q.dtmp = sv;
                  end
               endcase
               // Echo comes from the stored magnitude
               next_q.bin = is_tmp ? q.val : sv;
               next_q.start = 1'b1;
               next_q.st = ST_CONV;
            end
         end
         ST_CONV: begin
            // Input is ignored until the reply is done
            if (conv_done) begin
               next_q.st = ST_SEND;
               next_q.col = 5'h00;
               next_q.txv = 1'b1;
               next_q.txd = char_at(5'h00, q.op, q.s2, q.neg, bcd);
            end
         end
         ST_SEND: begin
            if (tx_go) begin
               if (q.col == rlen - 5'h01) begin
                  next_q.txv = 1'b0;
                  next_q.st = ST_IDLE;
               end else begin
                  next_q.col = q.col + 5'h01;
                  next_q.txd = char_at(q.col + 5'h01, q.op, q.s2,
                                       q.neg, bcd);
               end
            end
         end
         default: next_q.st = ST_IDLE;
      endcase
   end

   // State register; a low clock enable holds everything
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         q <= RST;
      end else if (I_CE) begin
         q <= next_q;
      end
   end

   assign O_PRDATA = q.prdata;
   assign O_PREADY = q.pready;
   assign O_PSLVERR = q.pslverr;
   assign O_TX_VALID = q.txv;
   assign O_TX_DATA = q.txd;
   assign O_ARM_LIGHT = q.arm_l;
   assign O_ARM_DARK = q.arm_d;
   assign O_FW_UPG_EN = q.s2;

   // Checks
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_NRST);

   sequence s_arm_cmd(logic [7:0] c);
      I_CE && q.st == ST_END && q.op == c && rx_ok && I_RX_DATA == CH_X;
   endsequence

   sequence s_tx_step(logic [4:0] c);
      I_CE && tx_go && q.col == c;
   endsequence

   AST_ARM_LIGHT: assert property (
      s_arm_cmd(CH_UA) |=> q.arm_l && O_TX_VALID && O_TX_DATA == CH_Z)
      else $error("light arm not taken");
   AST_ARM_DARK: assert property (
      s_arm_cmd(CH_UB) |=> q.arm_d && O_TX_VALID && O_TX_DATA == CH_Z)
      else $error("dark arm not taken");
   AST_DISARM: assert property (
      s_arm_cmd(CH_UD) |=> !q.arm_l && !q.arm_d)
      else $error("disarm left a mode armed");
   AST_LOCK_CHAR: assert property (
      s_tx_step(5'h02) ##0 is_arm |=>
      O_TX_DATA == ($past(q.s2) ? CH_UU : CH_UL))
      else $error("lock column wrong");
   AST_CAL_RUN: assert property (
      I_CE && q.s2 && q.arm_l && q.st != ST_END && q.st != ST_FIX |=>
      !q.arm_l && q.lofs == $past(I_MEAS_LIGHT))
      else $error("armed light calibration did not run");
   AST_LOCKED_WAIT: assert property (
      I_CE && !q.s2 && q.arm_l && q.st != ST_END |=> q.arm_l)
      else $error("calibration ran while locked");
   AST_DARK_LIMIT: assert property (
      q.dper <= DARK_MAX_MS)
      else $error("dark period above limit");
   AST_CRLF: assert property (
      s_tx_step(rlen - 5'h02) |-> O_TX_DATA == CH_CR ##1
      O_TX_DATA == CH_LF)
      else $error("reply does not end in CR LF");
   AST_OFS_SUFFIX: assert property (
      O_TX_VALID && q.op == CH_5 && q.col == 5'h0F |-> O_TX_DATA == CH_M)
      else $error("offset suffix missing");
   AST_STORE_ECHO: assert property (
      I_CE && q.st == ST_FIX && q.fc == fmax && q.op == CH_5 |=>
      q.start && q.bin == q.lofs)
      else $error("echo not taken from stored value");
   AST_TEMP_RAW: assert property (
      I_CE && rx_ok && q.st == ST_NUM && is_tmp && q.pt &&
      q.fc == FRAC_TMP && I_RX_DATA[7:4] == CH_0[7:4] |=>
      q.val == $past(q.val))
      else $error("temperature kept too fine");
   AST_BUSY: assert property (
      q.st == ST_CONV |=> q.st == ST_CONV || q.st == ST_SEND)
      else $error("left conversion early");
endmodule
`default_nettype wire

// *** include/cch_pkg.sv ***
/*
 * cch_pkg: constants and types of the calibration command handler.
 * Assumes 8-bit ASCII characters and a 32-bit APB register bus.
 */
`default_nettype none
package cch_pkg;
   // ASCII characters used by the parser and the replies
   localparam logic [7:0] CH_Z = 8'h7A;
   localparam logic [7:0] CH_C_LO = 8'h63;
   localparam logic [7:0] CH_A_LO = 8'h61;
   localparam logic [7:0] CH_L_LO = 8'h6C;
   localparam logic [7:0] CH_D_LO = 8'h64;
   localparam logic [7:0] CH_X = 8'h78;
   localparam logic [7:0] CH_UA = 8'h41;
   localparam logic [7:0] CH_UB = 8'h42;
   localparam logic [7:0] CH_UC = 8'h43;
   localparam logic [7:0] CH_UD = 8'h44;
   localparam logic [7:0] CH_UL = 8'h4C;
   localparam logic [7:0] CH_UU = 8'h55;
   localparam logic [7:0] CH_M = 8'h6D;
   localparam logic [7:0] CH_S = 8'h73;
   localparam logic [7:0] CH_COMMA = 8'h2C;
   localparam logic [7:0] CH_DOT = 8'h2E;
   localparam logic [7:0] CH_MINUS = 8'h2D;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_5 = 8'h35;
   localparam logic [7:0] CH_6 = 8'h36;
   localparam logic [7:0] CH_7 = 8'h37;
   localparam logic [7:0] CH_8 = 8'h38;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   // Reply layout: lengths, first field column, point and last column
   localparam logic [4:0] LEN_ARM = 5'h06;
   localparam logic [4:0] LEN_VAL = 5'h12;
   localparam logic [4:0] LEN_TMP = 5'h0C;
   localparam logic [4:0] COL_FIELD = 5'h04;
   localparam logic [3:0] PT_OFS = 4'h8;
   localparam logic [3:0] PT_PER = 4'h7;
   localparam logic [3:0] FLD_LAST = 4'hB;
   // Fraction digits kept per value kind
   localparam logic [1:0] FRAC_OFS = 2'h2;
   localparam logic [1:0] FRAC_PER = 2'h3;
   localparam logic [1:0] FRAC_TMP = 2'h1;
   localparam logic [31:0] TEN = 32'h0000000A;
   // Dark period limit, stored in milliseconds
   localparam logic [31:0] DARK_MAX_S = 32'h0000012C;
   localparam logic [31:0] MS_PER_S = 32'h000003E8;
   localparam logic [31:0] DARK_MAX_MS = 32'(DARK_MAX_S * MS_PER_S);
   // Register offsets, bits and reset values
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_LOFS = 8'h08;
   localparam logic [7:0] A_LTMP = 8'h0C;
   localparam logic [7:0] A_DPER = 8'h10;
   localparam logic [7:0] A_DTMP = 8'h14;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int SB_ARML = 0;
   localparam int SB_ARMD = 1;
   localparam int SB_UNL = 2;
   localparam int SB_BUSY = 3;
   // Converter sizes
   localparam int BIN_W = 32;
   localparam int BCD_DIG = 10;
   localparam int BCD_W = 40;
   localparam logic [5:0] BCD_STEPS = 6'h20;
   // Parser and reply states
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_HDR = 8'h02,
      ST_OP = 8'h04,
      ST_END = 8'h08,
      ST_NUM = 8'h10,
      ST_FIX = 8'h20,
      ST_CONV = 8'h40,
      ST_SEND = 8'h80
   } cch_state_t;
endpackage
`default_nettype wire

// *** tb/cch_host.sv ***
/*
 * cch_host: host computer model on the serial side of the command handler.
 * Assumes one-cycle character strobes on the handler's clock; the caller
 * clears rep and waits for a whole reply before sending again.
 */
`default_nettype none
module cch_host (
   input wire logic i_clk, // Handler clock
   input wire logic i_tx_valid, // Reply character valid
   input wire logic [7:0] i_tx_data, // Reply character
   output logic o_rx_valid, // Command character strobe
   output logic [7:0] o_rx_data, // Command character
   output logic o_tx_ready // Host takes reply character
);
   timeunit 1ns;
   timeprecision 1ns;
   string rep = "";
   logic slow = 1'b0;
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
      o_tx_ready = 1'b1;
   end
   // Slow mode takes a character only every other cycle
   always @(posedge i_clk) begin
      if (i_tx_valid && o_tx_ready)
         rep = $sformatf("%s%c", rep, i_tx_data);
      o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
   end
   // One command per call, the caller waits for the full reply
   task automatic send(string c);
      for (int i = 0; i < c.len(); i++) begin
         @(posedge i_clk);
         o_rx_valid <= 1'b1;
         o_rx_data <= c[i];
         @(posedge i_clk);
         o_rx_valid <= 1'b0;
         o_rx_data <= ~c[i]; // Data line never keeps a stale character
      end
   endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
 * tb: self-checking testbench of the calibration command handler.
 * Assumes the host model cch_host; APB answers are awaited, and only
 * the watchdog ends an APB wait that never finishes.
 */
`default_nettype none
module tb
   import cch_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic unl = 1'b0, pready, pslverr, rxv, txv, txr, arml, armd, fwe;
   logic ce = 1'b1;
   logic [7:0] paddr = 8'h00, rxd, txd;
   logic [31:0] pwdata = 32'h0, ml = 32'h0, md = 32'h0, prdata;
   logic [31:0] mt = 32'h0;
   int n_fail = 0, checked = 0;
   initial forever #5 clk = ~clk;
   cch_host host (.i_clk(clk), .i_tx_valid(txv), .i_tx_data(txd),
      .o_rx_valid(rxv), .o_rx_data(rxd), .o_tx_ready(txr));
   cch_calib_cmd dut (.I_CLK(clk), .I_NRST(nrst), .I_CE(ce),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_RX_VALID(rxv), .I_RX_DATA(rxd),
      .O_TX_VALID(txv), .I_TX_READY(txr), .O_TX_DATA(txd),
      .I_UNLOCK(unl), .I_MEAS_LIGHT(ml), .I_MEAS_DARK(md),
      .I_MEAS_TEMP(mt), .O_ARM_LIGHT(arml), .O_ARM_DARK(armd),
      .O_FW_UPG_EN(fwe));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic chk_s(string what, string exp, string got);
      checked++;
      if (got != exp) begin
         n_fail++;
         $display("mismatch %s exp %s got %s", what, exp, got);
      end
   endtask
   // Request held until pready is seen high at a rising edge
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
         output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rchk(logic [7:0] a, logic [31:0] exp);
      logic [31:0] v;
      logic e;
      apb(1'b0, a, 32'h0, v, e);
      chk($sformatf("reg %h", a), exp, v);
   endtask
   // Bounded wait for the whole reply before anything else is sent
   task automatic cmd(string c, string exp);
      int n = 0;
      host.rep = "";
      host.send(c);
      while (host.rep.len() < exp.len() && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk_s(c, exp, host.rep);
   endtask
   // Watchdog: the whole run needs several hundred cycles, far below the 10000 allowed here
   initial begin
      #100000;
      n_fail++;
      stop_test();
   end
   // Locked: arming waits, disarm reply taken in slow mode
   task automatic t_locked();
      cmd("zcalAx", "zAaL\r\n");
      chk("arm light", 32'h1, {31'h0, arml});
      cmd("zcalBx", "zBaL\r\n");
      rchk(A_STAT, 32'h3);
      host.slow = 1'b1;
      cmd("zcalDx", "zxdL\r\n");
      host.slow = 1'b0;
   endtask
   // Unlocked: calibration runs at once, dark period clamped
   task automatic t_unlocked();
      ml <= 32'h000006E0;
      md <= 32'h00061A80;
      mt <= 32'h000000FA;
      unl <= 1'b1;
      repeat (5) @(posedge clk);
      chk("fw upgrade", 32'h1, {31'h0, fwe});
      rchk(A_STAT, 32'h4);
      cmd("zcalAx", "zAaU\r\n");
      cmd("zcalBx", "zBaU\r\n");
      chk("arm dark", 32'h0, {31'h0, armd});
      rchk(A_STAT, 32'h4);
      rchk(A_LOFS, 32'h000006E0);
      rchk(A_LTMP, 32'h000000FA);
      rchk(A_DTMP, 32'h000000FA);
      rchk(A_DPER, 32'h000493E0);
      unl <= 1'b0;
   endtask
   // Manual values; extra fraction digits are dropped
   task automatic t_manual();
      cmd("zcal512.345x", "z,5,00000012.34m\r\n");
      rchk(A_LOFS, 32'h000004D2);
      cmd("zcal619x", "z,6,019.0C\r\n");
      rchk(A_LTMP, 32'h000000BE);
      cmd("zcal8-5.25x", "z,8,-05.2C\r\n");
      rchk(A_DTMP, 32'hFFFFFFCC);
      cmd("zcal7250.5x", "z,7,0000250.500s\r\n");
      rchk(A_DPER, 32'h0003D284);
      cmd("zcal7999x", "z,7,0000300.000s\r\n");
   endtask
   // Unmapped address errors; disabled receiver drops commands
   task automatic t_disabled();
      logic [31:0] v;
      logic er;
      apb(1'b0, 8'h20, 32'h0, v, er);
      chk("slverr", 32'h1, {31'h0, er});
      apb(1'b1, A_CTRL, 32'h0, v, er);
      host.rep = "";
      host.send("zcalAx");
      repeat (40) @(posedge clk);
      chk_s("disabled", "", host.rep);
      chk("arm off", 32'h0, {31'h0, arml});
   endtask
   // Low clock enable freezes the lock synchroniser too
   task automatic t_hold();
      ce <= 1'b0;
      unl <= 1'b1;
      repeat (5) @(posedge clk);
      chk("ce hold", 32'h0, {31'h0, fwe});
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      chk("ce run", 32'h1, {31'h0, fwe});
   endtask
   // Mid-run reset restores the enable and clears stored values
   task automatic t_reset();
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("reset fw", 32'h0, {31'h0, fwe});
      nrst <= 1'b1;
      rchk(A_CTRL, 32'h1);
      rchk(A_LOFS, 32'h0);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      t_locked();
      t_unlocked();
      t_manual();
      t_disabled();
      t_hold();
      t_reset();
      stop_test();
   end
endmodule
`default_nettype wire
